// ### verilog/rsc_map.svh
// Register offsets, field positions, reset values and timing counts of the reset source controller.
// Assumes inclusion by the design file only.
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
`define RSC_SUPPLY_IDX 8'hff
`define RSC_SUPPLY_ADDR 12'h3fc
`define RSC_CAUSE_ADDR 12'h400
`define RSC_CORE_ADDR 12'h404
`define RSC_SUP_EN_BIT 7
`define RSC_SUP_STAT_BIT 6
`define RSC_CMP_BIT 5
`define RSC_CLK_BIT 2
`define RSC_POR_BIT 1
`define RSC_PIN_BIT 0
`define RSC_PORT_RESET 8'hff
`define RSC_FETCH_ADDR 16'h0000
`define RSC_WDT_DIV 12
`define RSC_CLK_MHZ 100
`define RSC_POR_DELAY_US 300
`define RSC_CLK_LOSS_US 100
`define RSC_POR_DELAY_CYC (`RSC_POR_DELAY_US * `RSC_CLK_MHZ)
`define RSC_CLK_LOSS_CYC (`RSC_CLK_LOSS_US * `RSC_CLK_MHZ)
`endif

// ### verilog/rsc_pkg.sv
// Types shared by the reset source controller and its bench.
// Assumes nothing beyond the map header.
package rsc_pkg;
   typedef enum logic [2:0] {
      RSC_ST_POR = 3'b001,
      RSC_ST_HOLD = 3'b010,
      RSC_ST_RUN = 3'b100
   } rsc_state_t;
   typedef struct packed {
      logic halt;
      logic regs_init;
      logic irq_tmr_off;
      logic sp_init;
      logic clk_internal;
      logic wdt_enable;
      logic [15:0] fetch_addr;
   } rsc_core_t;
   typedef struct packed {
      logic [7:0] latch;
      logic open_drain;
      logic weak_pullup;
   } rsc_port_t;
endpackage

// ### verilog/rsc_reset_source_controller.sv
// Reset source controller: combines reset requests and drives core reset state.
// Assumes synchronous inputs, an AXI4-Lite master, and a separate clock-loss sense input.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rsc_map.svh"
module rsc_reset_source_controller #(
   parameter int POR_DELAY_CYC = `RSC_POR_DELAY_CYC,
   parameter int CLK_LOSS_CYC = `RSC_CLK_LOSS_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_activity,
   input wire logic supply_above_threshold,
   input wire logic reset_pin_n_in,
   output logic reset_pin_n_out,
   output logic reset_pin_oe,
   input wire logic comparator_out,
   input wire logic rmw_read,
   output logic system_reset,
   output rsc_pkg::rsc_core_t core_ctrl,
   output rsc_pkg::rsc_port_t port_ctrl,
   output logic wdt_tick,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import rsc_pkg::*;

   // Refuse values the counters cannot serve
   if (POR_DELAY_CYC < 1 || CLK_LOSS_CYC < 2) begin : g_delay_check
      $error("rsc: delay parameters out of range");
   end
   if (`RSC_WDT_DIV < 2 || `RSC_WDT_DIV > 16) begin : g_wdt_check
      $error("rsc: watchdog divider does not fit its counter");
   end

   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   function automatic logic is_mapped(input logic [11:0] a);
      return a == `RSC_SUPPLY_ADDR || a == `RSC_CAUSE_ADDR || a == `RSC_CORE_ADDR;
   endfunction

   // Core is held in every state but run
   function automatic logic in_reset(input rsc_state_t s);
      return s != RSC_ST_RUN;
   endfunction

   // Release only once both the live and the registered request are gone
   function automatic logic may_release(input logic live, input logic seen);
      return !live && !seen;
   endfunction

   // Last count of the watchdog prescaler
   function automatic logic wdt_last(input logic [3:0] count);
      return count == 4'(`RSC_WDT_DIV - 1);
   endfunction

   rsc_state_t state_reg;
   logic sup_en_reg;
   logic sup_sel_reg;
   logic clk_en_reg;
   logic cmp_en_reg;
   logic por_flag_reg;
   logic pin_flag_reg;
   logic clk_flag_reg;
   logic cmp_flag_reg;
   logic src_sup_reg;
   logic src_pin_reg;
   logic src_clk_reg;
   logic src_cmp_reg;
   logic [31:0] delay_reg;
   logic [31:0] stuck_reg;
   logic act_last_reg;
   logic [3:0] wdt_div_reg;
   logic req_reg;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [11:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic wstrb0_reg;

   logic req_sup;
   logic req_pin;
   logic req_clk;
   logic req_cmp;
   logic req_any;
   logic clk_lost;
   logic wr_fire;
   logic wr_cause;
   logic wr_supply;
   logic [7:0] cause_rd;

   assign req_sup = sup_en_reg && sup_sel_reg && !supply_above_threshold;
   // The pin reads back our own drive; only an outside low counts
   assign req_pin = !reset_pin_n_in && !reset_pin_oe;
   assign clk_lost = stuck_reg >= 32'(CLK_LOSS_CYC);
   assign req_clk = clk_en_reg && clk_lost;
   assign req_cmp = cmp_en_reg && !comparator_out;
   assign req_any = req_sup || req_pin || req_clk || req_cmp;

   // Release synchronised through one register stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_reg <= 1'b1;
      end else begin
         req_reg <= req_any;
      end
   end

   // Clock-loss one-shot: counts cycles with no activity toggle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stuck_reg <= 32'h0;
         act_last_reg <= 1'b0;
      end else begin
         act_last_reg <= clk_activity;
         if (act_last_reg != clk_activity || !clk_en_reg) begin
            stuck_reg <= 32'h0;
         end else if (!clk_lost) begin
            stuck_reg <= stuck_reg + 32'h1;
         end
      end
   end

   // Reset state machine
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= RSC_ST_POR;
         delay_reg <= 32'h0;
      end else begin
         unique case (state_reg)
            RSC_ST_POR: begin
               if (!supply_above_threshold) begin
                  delay_reg <= 32'h0;
               end else if (delay_reg >= 32'(POR_DELAY_CYC - 1)) begin
                  state_reg <= RSC_ST_RUN;
               end else begin
                  delay_reg <= delay_reg + 32'h1;
               end
            end
            RSC_ST_HOLD: begin
               if (may_release(req_any, req_reg)) begin
                  state_reg <= RSC_ST_RUN;
               end
            end
            RSC_ST_RUN: begin
               if (req_any) begin
                  state_reg <= RSC_ST_HOLD;
               end
            end
            default: state_reg <= RSC_ST_POR;
         endcase
      end
   end

   // Sources seen during the current reset, turned into flags on exit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src_sup_reg <= 1'b0;
         src_pin_reg <= 1'b0;
         src_clk_reg <= 1'b0;
         src_cmp_reg <= 1'b0;
      end else if (state_reg == RSC_ST_RUN && !req_any) begin
         src_sup_reg <= 1'b0;
         src_pin_reg <= 1'b0;
         src_clk_reg <= 1'b0;
         src_cmp_reg <= 1'b0;
      end else begin
         src_sup_reg <= src_sup_reg | req_sup;
         src_pin_reg <= src_pin_reg | req_pin;
         src_clk_reg <= src_clk_reg | req_clk;
         src_cmp_reg <= src_cmp_reg | req_cmp;
      end
   end

   // Cause flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         por_flag_reg <= 1'b1;
         pin_flag_reg <= 1'b0;
         clk_flag_reg <= 1'b0;
         cmp_flag_reg <= 1'b0;
      end else if (state_reg == RSC_ST_HOLD && may_release(req_any, req_reg)) begin
         por_flag_reg <= src_sup_reg;
         pin_flag_reg <= src_pin_reg;
         clk_flag_reg <= src_clk_reg;
         cmp_flag_reg <= src_cmp_reg;
      end
   end

   // Write decode
   assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   assign wr_cause = wr_fire && wstrb0_reg && awaddr_reg == `RSC_CAUSE_ADDR;
   assign wr_supply = wr_fire && wstrb0_reg && awaddr_reg == `RSC_SUPPLY_ADDR;

   // Supply monitor enable survives all but power-on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sup_en_reg <= 1'b0;
      end else if (state_reg == RSC_ST_POR) begin
         sup_en_reg <= 1'b0;
      end else if (wr_supply) begin
         sup_en_reg <= wdata_reg[`RSC_SUP_EN_BIT];
      end
   end

   // Source enables; power-on clears them, other resets keep them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sup_sel_reg <= 1'b0;
         clk_en_reg <= 1'b0;
         cmp_en_reg <= 1'b0;
      end else if (state_reg == RSC_ST_POR) begin
         sup_sel_reg <= 1'b0;
         clk_en_reg <= 1'b0;
         cmp_en_reg <= 1'b0;
      end else if (wr_cause) begin
         sup_sel_reg <= wdata_reg[`RSC_POR_BIT];
         clk_en_reg <= wdata_reg[`RSC_CLK_BIT];
         cmp_en_reg <= wdata_reg[`RSC_CMP_BIT];
      end
   end

   // Watchdog clock enable at system clock over twelve
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wdt_div_reg <= 4'h0;
         wdt_tick <= 1'b0;
      end else if (in_reset(state_reg)) begin
         wdt_div_reg <= 4'h0;
         wdt_tick <= 1'b0;
      end else begin
         wdt_tick <= wdt_last(wdt_div_reg);
         wdt_div_reg <= wdt_last(wdt_div_reg) ? 4'h0 : wdt_div_reg + 4'h1;
      end
   end

   // Core and port outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         system_reset <= 1'b1;
         core_ctrl <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, `RSC_FETCH_ADDR};
         port_ctrl <= '{`RSC_PORT_RESET, 1'b1, 1'b1};
      end else begin
         system_reset <= in_reset(state_reg);
         core_ctrl.halt <= in_reset(state_reg);
         core_ctrl.regs_init <= in_reset(state_reg);
         core_ctrl.irq_tmr_off <= in_reset(state_reg);
         core_ctrl.sp_init <= in_reset(state_reg);
         core_ctrl.clk_internal <= 1'b1;
         core_ctrl.wdt_enable <= !in_reset(state_reg);
         core_ctrl.fetch_addr <= `RSC_FETCH_ADDR;
         port_ctrl.latch <= `RSC_PORT_RESET;
         port_ctrl.open_drain <= in_reset(state_reg);
         port_ctrl.weak_pullup <= 1'b1;
      end
   end

   // Reset pin: open-drain, pulled low only during power-on and supply-monitor resets
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reset_pin_n_out <= 1'b0;
         reset_pin_oe <= 1'b1;
      end else begin
         reset_pin_n_out <= 1'b0;
         reset_pin_oe <= state_reg == RSC_ST_POR || (in_reset(state_reg) && src_sup_reg);
      end
   end

   // AXI4-Lite write channel
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= 12'h0;
         wdata_reg <= 8'h0;
         wstrb0_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(awaddr_reg) ? RESP_OK : RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;

   // Cause read shows enables during read-modify-write
   always_comb begin
      cause_rd = 8'h0;
      if (rmw_read) begin
         cause_rd[`RSC_CMP_BIT] = cmp_en_reg;
         cause_rd[`RSC_CLK_BIT] = clk_en_reg;
         cause_rd[`RSC_POR_BIT] = sup_sel_reg;
      end else begin
         cause_rd[`RSC_CMP_BIT] = cmp_flag_reg;
         cause_rd[`RSC_CLK_BIT] = clk_flag_reg;
         cause_rd[`RSC_POR_BIT] = por_flag_reg;
         cause_rd[`RSC_PIN_BIT] = pin_flag_reg;
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
         unique case (s_axi_araddr)
            `RSC_SUPPLY_ADDR: s_axi_rdata <= {24'h0, sup_en_reg, supply_above_threshold, 6'h0};
            `RSC_CAUSE_ADDR: s_axi_rdata <= {24'h0, cause_rd};
            `RSC_CORE_ADDR: s_axi_rdata <= {29'h0, state_reg};
            default: s_axi_rdata <= 32'h0;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;
endmodule

// ### bench/rsc_monitor.sv
// Checker of the reset source controller outputs.
// Assumes binding to the controller top module.
`timescale 1ns/1ps
module rsc_monitor #(
   parameter int POR_DELAY_CYC = 8,
   parameter int CLK_LOSS_CYC = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reset_pin_n_in,
   input wire logic reset_pin_n_out,
   input wire logic reset_pin_oe,
   input wire logic system_reset,
   input wire rsc_pkg::rsc_core_t core_ctrl,
   input wire rsc_pkg::rsc_port_t port_ctrl,
   input wire logic wdt_tick
);
   import rsc_pkg::*;
   logic [3:0] gap_reg;
   logic seen_reg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Cycles since the last watchdog tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) gap_reg <= 4'h0;
      else if (wdt_tick) gap_reg <= 4'h0;
      else gap_reg <= gap_reg + 4'h1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) seen_reg <= 1'b0;
      else if (system_reset) seen_reg <= 1'b0;
      else if (wdt_tick) seen_reg <= 1'b1;
   end
   AST_PIN_IN_RESET: assert property (reset_pin_oe |-> system_reset)
      else $error("reset pin driven outside reset");
   AST_PIN_LOW: assert property (reset_pin_oe |-> !reset_pin_n_out && !reset_pin_n_in)
      else $error("reset pin not low while driven");
   AST_CORE_HELD: assert property (system_reset |-> core_ctrl.halt && core_ctrl.regs_init
      && core_ctrl.irq_tmr_off && core_ctrl.sp_init) else $error("core not held in reset");
   AST_PORT_HELD: assert property (system_reset |-> port_ctrl.latch == 8'hff && port_ctrl.open_drain)
      else $error("port latches not forced");
   AST_PULLUP: assert property (port_ctrl.weak_pullup)
      else $error("weak pullup off");
   AST_EXIT: assert property ($fell(system_reset) |-> core_ctrl.clk_internal && core_ctrl.wdt_enable
      && !core_ctrl.halt && core_ctrl.fetch_addr == 16'h0000) else $error("bad state on reset exit");
   AST_WDT_GAP: assert property (wdt_tick && seen_reg |-> gap_reg == 4'hb)
      else $error("watchdog tick spacing wrong");
   AST_WDT_QUIET: assert property (system_reset |-> !wdt_tick)
      else $error("watchdog ticks in reset");
   AST_PIN_RELEASE: assert property ($fell(system_reset) && !$past(reset_pin_oe)
      |-> $past(reset_pin_n_in)) else $error("reset left while pin low");
endmodule

// ### bench/rsc_far_side.sv
// Far-side model: watched clock, supply supervisor, comparator, reset pin.
// Assumes the bench commands each source.
`timescale 1ns/1ps
module rsc_far_side (
   input wire logic clk,
   input wire logic clk_run,
   input wire logic supply_ok,
   input wire logic cmp_high,
   input wire logic pin_pull_low,
   input wire logic reset_pin_n_out,
   input wire logic reset_pin_oe,
   output logic clk_activity,
   output logic supply_above_threshold,
   output logic comparator_out,
   output logic reset_pin_n_in
);
   initial clk_activity = 1'b0;
   // Watched clock stops when told to
   always @(posedge clk) if (clk_run) clk_activity <= !clk_activity;
   assign supply_above_threshold = supply_ok;
   assign comparator_out = cmp_high;
   // Pulled up unless either party pulls low
   assign reset_pin_n_in = !(pin_pull_low || (reset_pin_oe && !reset_pin_n_out));
endmodule

// ### bench/reset_source_controller_test.sv
// Self-checking bench of the reset source controller.
// Assumes the design, far-side model and monitor files.
`timescale 1ns/1ps
module reset_source_controller_test;
   import rsc_pkg::*;
   localparam int PD = 8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk_run = 1'b1, sup_ok = 1'b1, cmp_hi = 1'b1, pin_lo = 1'b0, rmw = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdat, rdw;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic act, sup, cmp, pin_n, pin_out, pin_oe, sys_rst, seen_oe, awready, wready, bvalid;
   logic arready, rvalid, wdt;
   logic [1:0] bresp, rresp, rr;
   rsc_core_t core;
   rsc_port_t port;
   int failures = 0, n_checks = 0, cyc = 0, exp_en = 0;
   always #5 clk = ~clk;
   rsc_reset_source_controller #(.POR_DELAY_CYC(PD), .CLK_LOSS_CYC(8)) dut (
      .clk(clk), .rst(rst), .clk_activity(act), .supply_above_threshold(sup),
      .reset_pin_n_in(pin_n), .reset_pin_n_out(pin_out), .reset_pin_oe(pin_oe),
      .comparator_out(cmp), .rmw_read(rmw), .system_reset(sys_rst), .core_ctrl(core),
      .port_ctrl(port), .wdt_tick(wdt), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdw), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   rsc_far_side far (.clk(clk), .clk_run(clk_run), .supply_ok(sup_ok), .cmp_high(cmp_hi),
      .pin_pull_low(pin_lo), .reset_pin_n_out(pin_out), .reset_pin_oe(pin_oe), .clk_activity(act),
      .supply_above_threshold(sup), .comparator_out(cmp), .reset_pin_n_in(pin_n));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (awvalid && awready) aw = 1'b1;
         if (wvalid && wready) w = 1'b1;
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", 32'h0, 32'(bresp));
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rdat = rdw;
      rr = rresp;
      rready <= 1'b0;
   endtask
   task automatic hold;
      while (sys_rst !== 1'b1) @(posedge clk);
   endtask
   task automatic rel(output int n);
      n = 0;
      seen_oe = 1'b0;
      while (sys_rst !== 1'b0) begin
         @(posedge clk);
         n++;
         seen_oe |= pin_oe;
      end
   endtask
   task print_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         print_verdict;
      end
   end
   initial begin
      int n;
      void'($urandom(32'hd113));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rel(n);
      chk("por_delay", 32'h1, 32'(n >= PD));
      chk("por_pin", 32'h1, 32'(seen_oe));
      rd(12'h400);
      chk("por_flag", 32'h2, rdat & 32'h2);
      rd(12'h3fc);
      chk("sup_por", 32'h40, rdat);
      rd(12'h404);
      chk("state", 32'h4, rdat);
      wr(12'h3fc, $urandom | 32'h80);
      rd(12'h3fc);
      chk("sup_en", 32'hc0, rdat);
      sup_ok <= 1'b0;
      repeat (20) @(posedge clk);
      chk("unselected", 32'h0, 32'(sys_rst));
      rd(12'h3fc);
      chk("sup_low", 32'h80, rdat);
      sup_ok <= 1'b1;
      repeat (10) @(posedge clk);
      exp_en = 2;
      wr(12'h400, 32'(exp_en));
      sup_ok <= 1'b0;
      hold();
      repeat (5) @(posedge clk);
      sup_ok <= 1'b1;
      rel(n);
      chk("sup_fast", 32'h1, 32'(n < PD));
      chk("sup_pin", 32'h1, 32'(seen_oe));
      rd(12'h3fc);
      chk("sup_kept", 32'hc0, rdat);
      pin_lo <= 1'b1;
      hold();
      repeat (4 + $urandom % 8) @(posedge clk);
      pin_lo <= 1'b0;
      rel(n);
      chk("pin_oe", 32'h0, 32'(seen_oe));
      rd(12'h400);
      chk("pin_flag", 32'h1, rdat & 32'h27);
      exp_en = 6;
      wr(12'h400, 32'(exp_en));
      clk_run <= 1'b0;
      hold();
      clk_run <= 1'b1;
      rel(n);
      chk("loss_oe", 32'h0, 32'(seen_oe));
      rd(12'h400);
      chk("loss_flag", 32'h4, rdat & 32'h27);
      rmw <= 1'b1;
      rd(12'h400);
      chk("rmw", 32'(exp_en), rdat & 32'h27);
      rmw <= 1'b0;
      wr(12'h400, 32'h26);
      cmp_hi <= 1'b0;
      hold();
      cmp_hi <= 1'b1;
      rel(n);
      chk("cmp_oe", 32'h0, 32'(seen_oe));
      rd(12'h400);
      chk("cmp_flag", 32'h20, rdat & 32'h27);
      rd(12'h500);
      chk("unmapped", 32'h2, 32'(rr));
      chk("unmapped_data", 32'h0, rdat);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rel(n);
      rd(12'h3fc);
      chk("sup_off", 32'h40, rdat);
      rmw <= 1'b1;
      rd(12'h400);
      chk("en_clear", 32'h0, rdat & 32'h27);
      print_verdict;
   end
endmodule
bind rsc_reset_source_controller rsc_monitor #(.POR_DELAY_CYC(POR_DELAY_CYC), .CLK_LOSS_CYC(CLK_LOSS_CYC)) mon (
   .clk(clk), .rst(rst), .reset_pin_n_in(reset_pin_n_in), .reset_pin_n_out(reset_pin_n_out),
   .reset_pin_oe(reset_pin_oe), .system_reset(system_reset), .core_ctrl(core_ctrl),
   .port_ctrl(port_ctrl), .wdt_tick(wdt_tick));
